//--- common/ispme_pkg.sv
// Package for the programming-mode entry and flash rule block.
package ispme_pkg;
  localparam int ISPME_WORD_W = 12;
  localparam int ISPME_ADDR_W = 12;
  localparam int ISPME_MEM_WORDS = 4096;  // Large part; small part is 2,048
  localparam int ISPME_MEM_WORDS_SMALL = 2048;
  localparam logic [ISPME_WORD_W-1:0] ISPME_ERASED = 12'hFFF;
  localparam int ISPME_ENTRY_LOWS = 9;
  localparam logic [3:0] ISPME_ENTRY_LOWS_C = 4'h9;
  localparam int ISPME_CLK_MHZ = 100;
  // Erase time in ms and the derived clock count
  localparam int ISPME_ERASE_MS = 500;
  localparam int ISPME_ERASE_CYC = ISPME_ERASE_MS * 1000 * ISPME_CLK_MHZ;
  // Programming-mode oscillator 128 kHz: enable every 781 cycles (rounded down)
  localparam int ISPME_PROG_KHZ = 128;
  localparam int ISPME_PROG_DIV = (ISPME_CLK_MHZ * 1000) / ISPME_PROG_KHZ;
  // Entry-detect clock: 4 MHz divided by 2**sel, sel from primary config word
  localparam int ISPME_DET_BASE_KHZ = 4000;
  localparam int ISPME_DET_BASE_DIV = (ISPME_CLK_MHZ * 1000) / ISPME_DET_BASE_KHZ;
  localparam int ISPME_DIVSEL_LSB = 0;
  localparam int ISPME_DIVSEL_W = 3;
  // Command codes
  localparam logic [3:0] ISPME_CMD_ERASE = 4'h0;
  localparam logic [3:0] ISPME_CMD_PROG_EXT = 4'h3;
  localparam logic [3:0] ISPME_CMD_LOAD = 4'h4;
  localparam logic [3:0] ISPME_CMD_PROG = 4'h5;
  localparam logic [3:0] ISPME_CMD_INC = 4'h7;
  localparam logic [3:0] ISPME_CMD_IDLE = 4'hF;

  typedef enum logic [1:0] {
    ISPME_RUN = 2'b00,
    ISPME_ENTERED = 2'b01,
    ISPME_PROG = 2'b10
  } ispme_mode_t;

  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic [ISPME_WORD_W-1:0] data;
  } ispme_cmd_t;

  typedef struct packed {
    logic [ISPME_WORD_W-1:0] word;
    logic busy;
  } ispme_rd_t;
endpackage

//--- design/ispme_top.sv
// Programming-mode entry detector and flash erase/program rules.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Program memory of 4,096 twelve-bit words plus configuration words.
// - Memory writes accepted only in programming mode, never while running.
// - Erase clears whole memory and both config words to all ones.
// - Programming only clears bits; ones come back only by full erase, or by srst for the config words.
// - Erase takes 500 ms before the erased state is reported.
// - Entry after nine consecutive low serial pin samples on detect clock.
// - After entry serial pin becomes open drain with pull-up, reads high.
// - With voltage applied, programming logic runs on 128 kHz enable.
// - Internal detect clock is one of eight rates, 31.25 kHz to 4 MHz.
// - Commands and data arrive on the cmd port; clock pin gives the detect edges when external.
// - On entry the device resets itself and makes all ports inputs.
// - Undriven pin yields command 1111, treated as idle.
module ispme_top
  import ispme_pkg::*;
#(
  parameter int ERASE_CYC = ISPME_ERASE_CYC,
  parameter int PROG_DIV = ISPME_PROG_DIV
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic serial_io_pin_in,
  input wire logic clock_input_vpp_pin,
  input wire logic vpp_present,
  input wire logic external_clocking,
  input wire logic master_clear_input,
  input wire ispme_cmd_t cmd,
  input wire logic [ISPME_ADDR_W-1:0] cmd_addr,
  input wire logic serial_drive_low,
  output logic serial_io_pin_out,
  output logic serial_io_pin_oe,
  output logic in_system_programming_mode,
  output logic device_reset,
  output logic ports_input_only,
  output logic prog_tick,
  output ispme_rd_t rd,
  output logic [ISPME_WORD_W-1:0] primary_config_word,
  output logic [ISPME_WORD_W-1:0] extended_config_word
);

  typedef struct packed {
    logic [1:0] sio_sync;
    logic [1:0] ck_sync;
    logic [1:0] vpp_sync;
    logic ck_last;
    ispme_mode_t mode;
    logic [3:0] low_cnt;
    logic [15:0] det_cnt;
    logic [9:0] prog_cnt;
    logic tick;
    logic [31:0] erase_cnt;
    logic erasing;
    logic [ISPME_WORD_W-1:0] latch;
    logic [ISPME_ADDR_W-1:0] ptr;
    logic [ISPME_WORD_W-1:0] word_out;
    logic [ISPME_WORD_W-1:0] cfg_pri;
    logic [ISPME_WORD_W-1:0] cfg_ext;
    logic pin_oe;
    logic rst_pulse;
    logic prog_mode;
    logic inputs_only;
  } ispme_state_t;

  ispme_state_t st;
  ispme_state_t next_st;
  logic [ISPME_WORD_W-1:0] mem [ISPME_MEM_WORDS];

  // Programming clears bits only, so a new value is ANDed with the old one
  function automatic logic [ISPME_WORD_W-1:0] clear_only(
    input logic [ISPME_WORD_W-1:0] old_w,
    input logic [ISPME_WORD_W-1:0] new_w
  );
    clear_only = old_w & new_w;
  endfunction

  // Detect-rate divisor: 4 MHz divided by a power of two chosen by the config word
  function automatic logic [15:0] det_div(input logic [ISPME_DIVSEL_W-1:0] sel);
    det_div = 16'(ISPME_DET_BASE_DIV) << sel;
  endfunction

  logic cmd_ok;
  logic mem_wr;
  logic [ISPME_WORD_W-1:0] mem_wdata;
  logic detect_edge;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.sio_sync = {st.sio_sync[0], serial_io_pin_in};
    next_st.ck_sync = {st.ck_sync[0], clock_input_vpp_pin};
    next_st.vpp_sync = {st.vpp_sync[0], vpp_present};
    next_st.ck_last = st.ck_sync[1];
    next_st.rst_pulse = 1'b0;
    next_st.tick = 1'b0;
    mem_wr = 1'b0;
    mem_wdata = ISPME_ERASED;
    // Detection clock: clock pin rises when external, divided base rate otherwise
    detect_edge = 1'b0;
    if (external_clocking) begin
      detect_edge = st.ck_sync[1] & ~st.ck_last;
    end else if (st.det_cnt >= det_div(st.cfg_pri[ISPME_DIVSEL_LSB +: ISPME_DIVSEL_W]) - 16'h1) begin
      next_st.det_cnt = 16'h0;
      detect_edge = 1'b1;
    end else begin
      next_st.det_cnt = st.det_cnt + 16'h1;
    end
    unique case (st.mode)
      ISPME_RUN: begin
        if (detect_edge) begin
          if (st.sio_sync[1]) begin
            next_st.low_cnt = 4'h0;
          end else if (st.low_cnt == ISPME_ENTRY_LOWS_C - 4'h1) begin
            next_st.mode = ISPME_ENTERED;
            next_st.rst_pulse = 1'b1;
            next_st.low_cnt = 4'h0;
          end else begin
            next_st.low_cnt = st.low_cnt + 4'h1;
          end
        end
      end
      ISPME_ENTERED: begin
        // Wait for the programming voltage only; the pin release is not checked here
        if (st.vpp_sync[1]) begin
          next_st.mode = ISPME_PROG;
          next_st.prog_cnt = 10'h0;
        end
      end
      ISPME_PROG: begin
        // Internal 128 kHz rate as a one-cycle enable
        if (st.prog_cnt == 10'(PROG_DIV - 1)) begin
          next_st.prog_cnt = 10'h0;
          next_st.tick = 1'b1;
        end else begin
          next_st.prog_cnt = st.prog_cnt + 10'h1;
        end
      end
      default: next_st.mode = ISPME_RUN;
    endcase
    // Open drain: only ever drive low, pull-up gives the high level
    next_st.pin_oe = (st.mode != ISPME_RUN) & serial_drive_low;
    cmd_ok = cmd.valid & (st.mode == ISPME_PROG) & st.tick & ~st.erasing;
    if (st.erasing) begin
      if (st.erase_cnt >= 32'(ERASE_CYC - 1)) begin
        next_st.erasing = 1'b0;
      end else begin
        next_st.erase_cnt = st.erase_cnt + 32'h1;
      end
    end
    if (cmd_ok) begin
      unique case (cmd.code)
        ISPME_CMD_ERASE: begin
          next_st.erasing = 1'b1;
          next_st.erase_cnt = 32'h0;
          next_st.cfg_pri = ISPME_ERASED;
          next_st.cfg_ext = ISPME_ERASED;
        end
        ISPME_CMD_LOAD: next_st.latch = cmd.data;
        ISPME_CMD_PROG: begin
          mem_wr = 1'b1;
          mem_wdata = clear_only(mem[st.ptr], st.latch);
        end
        ISPME_CMD_PROG_EXT: next_st.cfg_ext = clear_only(st.cfg_ext, st.latch);
        ISPME_CMD_INC: next_st.ptr = st.ptr + 12'h1;
        ISPME_CMD_IDLE: next_st.ptr = st.ptr;
        default: next_st.ptr = st.ptr;
      endcase
    end
    next_st.word_out = mem[st.ptr];
    if (cmd.valid && st.mode == ISPME_PROG && !st.erasing) begin
      next_st.ptr = (cmd_ok && cmd.code == ISPME_CMD_INC) ? st.ptr + 12'h1 : cmd_addr;
    end
    // Mode flags kept in flops so the outputs carry no decode glitches
    next_st.prog_mode = (next_st.mode == ISPME_PROG);
    next_st.inputs_only = (next_st.mode != ISPME_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; master clear is kept high by the programmer and is not watched here
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.sio_sync <= 2'b11;
      st.cfg_pri <= ISPME_ERASED;
      st.cfg_ext <= ISPME_ERASED;
      st.latch <= ISPME_ERASED;
      st.word_out <= ISPME_ERASED;
      st.mode <= ISPME_RUN;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flash array in flip-flops; erase fills it with ones in one cycle, busy then covers the erase time
  always_ff @(posedge sys_clk) begin
    if (cmd_ok && cmd.code == ISPME_CMD_ERASE) begin
      for (int i = 0; i < ISPME_MEM_WORDS; i++) begin
        mem[i] <= ISPME_ERASED;
      end
    end else if (mem_wr) begin
      mem[st.ptr] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops; the pin data output is tied low
  assign serial_io_pin_out = 1'b0;
  assign serial_io_pin_oe = st.pin_oe;
  assign in_system_programming_mode = st.prog_mode;
  assign device_reset = st.rst_pulse;
  assign ports_input_only = st.inputs_only;
  assign prog_tick = st.tick;
  assign rd = '{word: st.word_out, busy: st.erasing};
  assign primary_config_word = st.cfg_pri;
  assign extended_config_word = st.cfg_ext;

endmodule
`default_nettype wire

//--- tb/ispme_assertions.sv
// Checker for the programming-mode entry block.
`timescale 1ns/10ps
`default_nettype none
module ispme_checker
  import ispme_pkg::*;
#(
  parameter int ERASE_CYC = 100,
  parameter int PROG_DIV = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire ispme_cmd_t cmd,
  input wire logic serial_io_pin_out,
  input wire logic serial_io_pin_oe,
  input wire logic in_system_programming_mode,
  input wire logic device_reset,
  input wire logic ports_input_only,
  input wire logic prog_tick,
  input wire ispme_rd_t rd,
  input wire logic [ISPME_WORD_W-1:0] extended_config_word
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // Gaps and lengths assume the bench values ERASE_CYC 100, PROG_DIV 8
  a_open_drain: assert property (!serial_io_pin_out) else $error("pin driven high");
  a_oe_entered: assert property (serial_io_pin_oe |-> ports_input_only) else $error("early drive");
  a_reset_pulse: assert property (device_reset |=> !device_reset && ports_input_only)
    else $error("bad device reset");
  a_tick_mode: assert property (prog_tick |-> in_system_programming_mode) else $error("stray tick");
  a_tick_gap: assert property (prog_tick |=> (!prog_tick)[*7] ##1 prog_tick) else $error("tick gap");
  a_erase_start: assert property (cmd.valid && cmd.code == ISPME_CMD_ERASE && prog_tick && !rd.busy
    |=> rd.busy) else $error("erase not started");
  a_erase_len: assert property ($rose(rd.busy) |-> ##99 rd.busy ##1 !rd.busy) else $error("erase time");
  a_busy_mode: assert property (rd.busy |-> in_system_programming_mode) else $error("busy outside");
  a_mode_inputs: assert property (in_system_programming_mode |-> ports_input_only)
    else $error("ports active in mode");
  a_erase_cfg: assert property ($fell(rd.busy) |-> extended_config_word == 12'hFFF)
    else $error("config not erased");
endmodule
bind ispme_top ispme_checker #(.ERASE_CYC(ERASE_CYC), .PROG_DIV(PROG_DIV)) u_chk (
  .sys_clk(sys_clk), .srst(srst), .cmd(cmd), .serial_io_pin_out(serial_io_pin_out),
  .serial_io_pin_oe(serial_io_pin_oe), .in_system_programming_mode(in_system_programming_mode),
  .device_reset(device_reset), .ports_input_only(ports_input_only), .prog_tick(prog_tick),
  .rd(rd), .extended_config_word(extended_config_word));
`default_nettype wire

//--- tb/ispme_programmer.sv
// Behavioural programmer unit driving the serial and clock pins.
`timescale 1ns/10ps
`default_nettype none
module ispme_programmer (
  input wire logic sys_clk,
  output logic pin_low,
  output logic clk_pin,
  output logic vpp_on
);
  // Clock pin parked low so the device clock stands still
  initial begin
    pin_low = 1'b0;
    clk_pin = 1'b0;
    vpp_on = 1'b0;
  end
  // Slow toggles, since the device synchronises both pins
  task automatic toggles(input int n, input logic low);
    pin_low = low;
    repeat (n) begin
      repeat (4) @(negedge sys_clk);
      clk_pin = 1'b1;
      repeat (4) @(negedge sys_clk);
      clk_pin = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
  endtask
  // Unknown clock setting: hold the pin low for a fixed span of cycles
  task automatic hold_low(input int n);
    pin_low = 1'b1;
    repeat (n) @(negedge sys_clk);
    pin_low = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // Voltage only once the serial pin is let go
  task automatic power();
    if (!pin_low) vpp_on = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb/ispme_top_tb.sv
// Self-checking bench for the programming-mode entry block.
`timescale 1ns/10ps
`default_nettype none
module ispme_top_tb;
  import ispme_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic drv_low = 1'b1;
  logic ext_clk = 1'b1;
  logic tick;
  logic [11:0] cfg_p;
  logic rst_seen = 1'b0;
  ispme_cmd_t cmd = '0;
  logic [11:0] addr = 12'h000;
  logic p_low, osc, vpp, pin_out, pin_oe, mode, dev_rst, inputs_only;
  ispme_rd_t rd;
  logic [11:0] cfg_x;
  int errors = 0;
  int samples_checked = 0;
  // Pull-up wins unless someone pulls low
  wire logic pin = !(p_low || pin_oe);
  ispme_programmer prog (.sys_clk(sys_clk), .pin_low(p_low), .clk_pin(osc), .vpp_on(vpp));
  ispme_top #(.ERASE_CYC(100), .PROG_DIV(8)) dut (.sys_clk(sys_clk), .srst(srst),
    .serial_io_pin_in(pin), .clock_input_vpp_pin(osc), .vpp_present(vpp),
    .external_clocking(ext_clk), .master_clear_input(1'b1), .cmd(cmd), .cmd_addr(addr),
    .serial_drive_low(drv_low), .serial_io_pin_out(pin_out), .serial_io_pin_oe(pin_oe),
    .in_system_programming_mode(mode), .device_reset(dev_rst), .ports_input_only(inputs_only),
    .prog_tick(tick), .rd(rd), .primary_config_word(cfg_p), .extended_config_word(cfg_x));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // The reset pulse is one cycle, so latch it
  always @(posedge sys_clk) if (dev_rst === 1'b1) rst_seen <= 1'b1;
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Hold the command until a free tick takes it
  task automatic send(input logic [3:0] code, input logic [11:0] data, input logic [11:0] a);
    cmd = '{1'b1, code, data};
    addr = a;
    for (int i = 0; i < 400 && !(tick === 1'b1 && rd.busy === 1'b0); i++)
      @(negedge sys_clk);
    @(negedge sys_clk);
    cmd.valid = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  // Mid-run reset back to running mode; the erased array must refuse writes
  task automatic t_run_refused();
    srst = 1'b1;
    ext_clk = 1'b0;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    check("inputs_only", 12'h000, {11'h0, inputs_only});
    cmd = '{1'b1, ISPME_CMD_LOAD, 12'h000};
    repeat (20) @(negedge sys_clk);
    cmd.code = ISPME_CMD_PROG;
    repeat (20) @(negedge sys_clk);
    cmd.valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("word", 12'hFFF, rd.word);
    check("mode", 12'h000, {11'h0, mode});
  endtask
  // Internal detect clock at its slowest rate, fixed-span low hold
  task automatic t_internal_entry();
    prog.hold_low(31000);
    check("inputs_only", 12'h001, {11'h0, inputs_only});
  endtask
  task automatic t_entry();
    prog.toggles(8, 1'b1);
    prog.toggles(1, 1'b0);
    prog.toggles(8, 1'b1);
    check("inputs_only", 12'h000, {11'h0, inputs_only});
    check("reset_seen", 12'h000, {11'h0, rst_seen});
    prog.toggles(1, 1'b1);
    check("inputs_only", 12'h001, {11'h0, inputs_only});
    check("reset_seen", 12'h001, {11'h0, rst_seen});
    check("oe", 12'h001, {11'h0, pin_oe});
    drv_low = 1'b0;
    prog.toggles(0, 1'b0);
    check("pin", 12'h001, {11'h0, pin});
    prog.power();
    repeat (10) @(negedge sys_clk);
    check("mode", 12'h001, {11'h0, mode});
  endtask
  task automatic t_flash();
    send(ISPME_CMD_ERASE, 12'h000, 12'h000);
    check("busy", 12'h001, {11'h0, rd.busy});
    send(ISPME_CMD_LOAD, 12'hA5C, 12'h000);
    send(ISPME_CMD_PROG_EXT, 12'h000, 12'h000);
    check("ext_cfg", 12'hA5C, cfg_x);
    send(ISPME_CMD_LOAD, 12'h0F0, 12'h005);
    send(ISPME_CMD_PROG, 12'h000, 12'h005);
    check("word", 12'h0F0, rd.word);
    send(ISPME_CMD_LOAD, 12'hF3F, 12'h005);
    send(ISPME_CMD_PROG, 12'h000, 12'h005);
    check("word", 12'h030, rd.word);
    send(ISPME_CMD_IDLE, 12'h000, 12'h005);
    check("word", 12'h030, rd.word);
    send(ISPME_CMD_ERASE, 12'h000, 12'h005);
    repeat (110) @(negedge sys_clk);
    check("word", 12'hFFF, rd.word);
    check("ext_cfg", 12'hFFF, cfg_x);
    check("pri_cfg", 12'hFFF, cfg_p);
  endtask
  task automatic wrap_up();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    t_entry();
    t_flash();
    t_run_refused();
    t_internal_entry();
    wrap_up();
  end
  // Whole run is about 31,600 cycles, mostly the fixed-span low hold
  initial begin
    #800000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
